// *** core/itbu_pkg.sv ***
// Constants shared by the interrupt unit and its core-side partner.
// Assumes a single system clock and an active-high asynchronous reset.
package itbu_pkg;
    localparam int          ADDR_W           = 4;
    localparam int          DATA_W           = 8;
    // Register offsets of the device.
    localparam logic [3:0]  OFF_PSC0         = 4'h0;
    localparam logic [3:0]  OFF_PSC1         = 4'h1;
    localparam logic [3:0]  OFF_TIME_BASE0_CONTROL         = 4'h2;
    localparam logic [3:0]  OFF_TIME_BASE1_CONTROL         = 4'h3;
    localparam logic [3:0]  OFF_FLAGS        = 4'h4;
    localparam logic [3:0]  OFF_ENABLES      = 4'h5;
    localparam logic [3:0]  OFF_GRP          = 4'h6;
    localparam logic [3:0]  OFF_GLOBAL       = 4'h7;
    // Field positions, reset read value, time-base exponent and divider count.
    localparam int          TB_EN_BIT        = 7;
    localparam int          GIE_BIT          = 0;
    localparam logic [7:0]  RESET_VAL        = 8'h00;
    localparam int          TB_BASE_EXP      = 8;
    localparam int          DIV4_COUNT       = 4;
    // Source indices in the flag and enable registers.
    localparam int          SRC_TB0          = 0;
    localparam int          SRC_TB1          = 1;
    localparam int          SRC_SIM          = 2;
    localparam int          SRC_UART         = 3;
    localparam int          SRC_EEW          = 4;
    localparam int          SRC_LVD          = 5;
    localparam int          SRC_TMA          = 6;
    localparam int          SRC_TMP          = 7;
    localparam int          NUM_VEC          = 7;
    // Vector numbers, in fixed priority order, lowest number wins.
    localparam logic [2:0]  VEC_SIM          = 3'h0;
    localparam logic [2:0]  VEC_UART         = 3'h1;
    localparam logic [2:0]  VEC_TB0          = 3'h2;
    localparam logic [2:0]  VEC_TB1          = 3'h3;
    localparam logic [2:0]  VEC_MF0          = 3'h4;
    localparam logic [2:0]  VEC_MF1          = 3'h5;
    localparam logic [2:0]  VEC_MF2          = 3'h6;
endpackage

// *** core/itbu_if.sv ***
// Interface joining the interrupt unit and the core that services it.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface itbu_if;
    logic       [3:0]  addr;
    logic       [7:0]  wdata;
    logic              wr;
    logic              rd;
    logic       [7:0]  rdata;
    logic              irq_req;
    logic       [2:0]  irq_vec;
    logic              irq_ack;
    logic              stack_full;
    logic              return_from_interrupt_instr;
    logic              plain_return_instr;
    modport device (input addr, input wdata, input wr, input rd, output rdata, output irq_req, output irq_vec,
                    input irq_ack, input stack_full, input return_from_interrupt_instr,
                    input plain_return_instr);
    modport core (output addr, output wdata, output wr, output rd, input rdata, input irq_req, input irq_vec,
                  output irq_ack, output stack_full, output return_from_interrupt_instr,
                  output plain_return_instr);
endinterface

// *** core/interrupt_and_time_base_unit.sv ***
// Interrupt controller with two time-base generators, device end of itbu_if.
// Assumes sub clock and peripheral event inputs arrive from other domains as levels or pulses.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps
module interrupt_and_time_base_unit (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    itbu_if.device           bus,
    input  wire logic        sub_clock,
    input  wire logic        sim_byte_done,
    input  wire logic        sim_addr_match,
    input  wire logic        sim_bus_timeout,
    input  wire logic [5:0]  uart_events,
    input  wire logic        eeprom_write_done,
    input  wire logic        low_voltage,
    input  wire logic        timer_module_match_a,
    input  wire logic        timer_module_match_p,
    output logic             wake_up
);
    import itbu_pkg::*;

    typedef struct packed {
        logic [1:0]  prescaler0_source_field;
        logic [1:0]  prescaler1_source_field;
        logic [7:0]  time_base0_control;
        logic [7:0]  time_base1_control;
        logic [7:0]  flags;
        logic [7:0]  enables;
        logic [2:0]  group_request_flag;
        logic [2:0]  group_irq_enable;
        logic        global_irq_enable;
        logic [1:0]  div4_cnt;
        logic [14:0] tb0_cnt;
        logic [14:0] tb1_cnt;
        logic [11:0] sync1;
        logic [11:0] sync2;
        logic [11:0] sync3;
        logic [7:0]  rdata;
        logic        wake;
        logic        req;
        logic [2:0]  vec;
    } state_s;

    state_s st_reg;
    state_s st_next;

    logic [11:0] rise;
    logic        psc_tick0;
    logic        psc_tick1;
    logic [7:0]  new_set;
    logic [7:0]  clr_mask;
    logic [2:0]  grp_set;
    logic [6:0]  pend;
    logic [14:0] tb0_sum;
    logic [14:0] tb1_sum;

    function automatic logic prescale_tick(input logic [1:0] sel, input logic div4, input logic sub_rise);
        case (sel)
            2'b00:   prescale_tick = 1'b1;
            2'b01:   prescale_tick = div4;
            default: prescale_tick = sub_rise;
        endcase
    endfunction

    function automatic logic tb_overflow(input logic [14:0] cnt, input logic [2:0] code);
        tb_overflow = (cnt == ((15'h0001 << (TB_BASE_EXP + 32'(code))) - 15'h0001)) || (code == 3'h7 && &cnt);
    endfunction

    function automatic logic [2:0] first_vec(input logic [6:0] p);
        first_vec = VEC_SIM;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (p[i]) begin
                first_vec = 3'(i);
            end
        end
    endfunction

    always_comb begin
        st_next = st_reg;
        rise = st_reg.sync2 & ~st_reg.sync3;
        st_next.sync1 = {timer_module_match_p, timer_module_match_a, low_voltage, eeprom_write_done,
                         uart_events, sim_byte_done | sim_addr_match | sim_bus_timeout, sub_clock};
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        st_next.div4_cnt = st_reg.div4_cnt + 2'h1;
        psc_tick0 = prescale_tick(st_reg.prescaler0_source_field, &st_reg.div4_cnt, rise[0]);
        psc_tick1 = prescale_tick(st_reg.prescaler1_source_field, &st_reg.div4_cnt, rise[0]);
        tb0_sum = st_reg.tb0_cnt + 15'h0001;
        tb1_sum = st_reg.tb1_cnt + 15'h0001;
        new_set = '0;
        if (!st_reg.time_base0_control[TB_EN_BIT]) begin
            st_next.tb0_cnt = '0;
        end else if (psc_tick0) begin
            if (tb_overflow(st_reg.tb0_cnt, st_reg.time_base0_control[2:0])) begin
                st_next.tb0_cnt = '0;
                new_set[SRC_TB0] = 1'b1;
            end else begin
                st_next.tb0_cnt = tb0_sum;
            end
        end
        if (!st_reg.time_base1_control[TB_EN_BIT]) begin
            st_next.tb1_cnt = '0;
        end else if (psc_tick1) begin
            if (tb_overflow(st_reg.tb1_cnt, st_reg.time_base1_control[2:0])) begin
                st_next.tb1_cnt = '0;
                new_set[SRC_TB1] = 1'b1;
            end else begin
                st_next.tb1_cnt = tb1_sum;
            end
        end
        new_set[SRC_SIM]  = rise[1];
        new_set[SRC_UART] = |rise[7:2];
        new_set[SRC_EEW]  = rise[8];
        new_set[SRC_LVD]  = rise[9];
        new_set[SRC_TMA]  = rise[10];
        new_set[SRC_TMP]  = rise[11];
        grp_set = {new_set[SRC_TMP] & st_reg.enables[SRC_TMP],
                   new_set[SRC_TMA] & st_reg.enables[SRC_TMA],
                   (new_set[SRC_EEW] & st_reg.enables[SRC_EEW]) | (new_set[SRC_LVD] & st_reg.enables[SRC_LVD])};
        clr_mask = '0;
        st_next.rdata = RESET_VAL;
        if (bus.rd) begin
            case (bus.addr)
                OFF_PSC0:    st_next.rdata = {6'h00, st_reg.prescaler0_source_field};
                OFF_PSC1:    st_next.rdata = {6'h00, st_reg.prescaler1_source_field};
                OFF_TIME_BASE0_CONTROL:    st_next.rdata = st_reg.time_base0_control;
                OFF_TIME_BASE1_CONTROL:    st_next.rdata = st_reg.time_base1_control;
                OFF_FLAGS:   st_next.rdata = st_reg.flags;
                OFF_ENABLES: st_next.rdata = st_reg.enables;
                OFF_GRP:     st_next.rdata = {1'b0, st_reg.group_irq_enable, 1'b0, st_reg.group_request_flag};
                OFF_GLOBAL:  st_next.rdata = {7'h00, st_reg.global_irq_enable};
                default:     st_next.rdata = RESET_VAL;
            endcase
        end
        if (bus.wr) begin
            case (bus.addr)
                OFF_PSC0:    st_next.prescaler0_source_field = bus.wdata[1:0];
                OFF_PSC1:    st_next.prescaler1_source_field = bus.wdata[1:0];
                OFF_TIME_BASE0_CONTROL:    st_next.time_base0_control = {bus.wdata[7], 4'h0, bus.wdata[2:0]};
                OFF_TIME_BASE1_CONTROL:    st_next.time_base1_control = {bus.wdata[7], 4'h0, bus.wdata[2:0]};
                OFF_FLAGS:   st_next.flags = bus.wdata;
                OFF_ENABLES: st_next.enables = bus.wdata;
                OFF_GRP: begin
                    st_next.group_request_flag = bus.wdata[2:0];
                    st_next.group_irq_enable = bus.wdata[6:4];
                end
                OFF_GLOBAL:  st_next.global_irq_enable = bus.wdata[GIE_BIT];
                default:     st_next.rdata = st_next.rdata;
            endcase
        end
        if (bus.return_from_interrupt_instr && !bus.plain_return_instr) begin
            st_next.global_irq_enable = 1'b1;
        end
        if (bus.irq_ack) begin
            st_next.global_irq_enable = 1'b0;
            case (st_reg.vec)
                VEC_SIM:  clr_mask[SRC_SIM] = 1'b1;
                VEC_UART: clr_mask[SRC_UART] = 1'b1;
                VEC_TB0:  clr_mask[SRC_TB0] = 1'b1;
                VEC_TB1:  clr_mask[SRC_TB1] = 1'b1;
                VEC_MF0:  st_next.group_request_flag[0] = 1'b0;
                VEC_MF1:  st_next.group_request_flag[1] = 1'b0;
                VEC_MF2:  st_next.group_request_flag[2] = 1'b0;
                default:  clr_mask = '0;
            endcase
        end
        st_next.flags = (st_next.flags & ~clr_mask) | new_set;
        st_next.group_request_flag = st_next.group_request_flag | grp_set;
        st_next.wake = |(new_set & ~st_reg.flags);
        pend = {st_reg.group_request_flag & st_reg.group_irq_enable,
                st_reg.flags[SRC_TB1] & st_reg.enables[SRC_TB1],
                st_reg.flags[SRC_TB0] & st_reg.enables[SRC_TB0],
                st_reg.flags[SRC_UART] & st_reg.enables[SRC_UART],
                st_reg.flags[SRC_SIM] & st_reg.enables[SRC_SIM]};
        st_next.req = st_reg.global_irq_enable && !bus.stack_full && (|pend) && !bus.irq_ack;
        st_next.vec = first_vec(pend);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.rdata   = st_reg.rdata;
    assign bus.irq_req = st_reg.req;
    assign bus.irq_vec = st_reg.vec;
    assign wake_up     = st_reg.wake;
endmodule // interrupt_and_time_base_unit

// *** core/interrupt_core_end.sv ***
// Core end of itbu_if: forwards software accesses and takes interrupt entries.
// Assumes the user side supplies the stack depth in use and return strobes.
`timescale 1ns/100ps
module interrupt_core_end #(
    parameter int STACK_DEPTH = 8
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    itbu_if.core             bus,
    input  wire logic [3:0]  sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [7:0]  sw_rdata,
    input  wire logic [4:0]  stack_used,
    input  wire logic        ret_intr,
    input  wire logic        ret_plain,
    output logic             vector_taken,
    output logic      [2:0]  vector_num
);
    import itbu_pkg::*;

    typedef struct packed {
        logic       taken;
        logic [2:0] num;
    } state_s;

    state_s st_reg;
    state_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.taken = bus.irq_req;
        if (bus.irq_req) begin
            st_next.num = bus.irq_vec;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.addr                        = sw_addr;
    assign bus.wdata                       = sw_wdata;
    assign bus.wr                          = sw_wr;
    assign bus.rd                          = sw_rd;
    assign bus.irq_ack                     = bus.irq_req;
    assign bus.stack_full                  = 32'(stack_used) >= STACK_DEPTH;
    assign bus.return_from_interrupt_instr = ret_intr;
    assign bus.plain_return_instr          = ret_plain;
    assign sw_rdata                        = bus.rdata;
    assign vector_taken                    = st_reg.taken;
    assign vector_num                      = st_reg.num;
endmodule // interrupt_core_end

// *** tb/itbu_checker.sv ***
// Assertions on the signals of the interface joining the interrupt unit and its core end.
// Assumes one system clock and an active-high asynchronous reset.
`timescale 1ns/100ps
module itbu_checker (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       irq_req,
    input wire logic [2:0] irq_vec,
    input wire logic       irq_ack,
    input wire logic       stack_full,
    input wire logic       return_from_interrupt_instr,
    input wire logic       plain_return_instr
);
    import itbu_pkg::*;
    logic       gie_reg;
    logic [7:0] tb0_reg;
    logic [1:0] psc0_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Shadow copies of the global enable and two control registers.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gie_reg  <= 1'b0;
            tb0_reg  <= 8'h00;
            psc0_reg <= 2'h0;
        end else begin
            if (irq_req && irq_ack) gie_reg <= 1'b0;
            else if (return_from_interrupt_instr) gie_reg <= 1'b1;
            else if (wr && addr == OFF_GLOBAL) gie_reg <= wdata[GIE_BIT];
            if (wr && addr == OFF_TIME_BASE0_CONTROL) tb0_reg <= wdata & 8'h87;
            if (wr && addr == OFF_PSC0) psc0_reg <= wdata[1:0];
        end
    end
    psc_read_a: assert property (rd && addr == OFF_PSC0 |=> rdata == {6'h00, psc0_reg})
        else $error("prescaler select read back wrong");
    tb_read_a: assert property (rd && addr == OFF_TIME_BASE0_CONTROL |=> rdata == tb0_reg)
        else $error("time base control read back wrong");
    vec_gate_a: assert property ($rose(irq_req) |-> $past(gie_reg) && !$past(stack_full))
        else $error("request raised without global enable or stack room");
    stack_block_a: assert property (stack_full && !irq_req |=> !irq_req)
        else $error("request raised while stack full");
    ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req)
        else $error("request not dropped after service");
    plain_ret_a: assert property ((irq_req && irq_ack) ##1 (!return_from_interrupt_instr &&
        !(wr && addr == OFF_GLOBAL)) [*3] |=> !irq_req)
        else $error("request raised without global enable set again");
    vec_range_a: assert property (irq_req |-> irq_vec <= VEC_MF2)
        else $error("vector number out of range");
    core_ack_a: assert property (irq_req |-> irq_ack)
        else $error("core did not take the presented request");
    cover property (irq_req && irq_ack);
    cover property (return_from_interrupt_instr);
    cover property (plain_return_instr);
endmodule // itbu_checker

// *** tb/tb_top.sv ***
// Self-checking bench joining the interrupt unit and its core end through itbu_if.
// Assumes a 200 MHz system clock; expectations are queued and compared by a monitor.
`timescale 1ns/100ps
module tb_top;
    import itbu_pkg::*;
    logic        clk_sys;
    logic        rst;
    logic        sub_clock;
    logic [12:0] ev;
    logic [3:0]  sw_addr;
    logic [7:0]  sw_wdata;
    logic        sw_wr;
    logic        sw_rd;
    logic [7:0]  sw_rdata;
    logic [4:0]  stack_used;
    logic        ret_intr;
    logic        ret_plain;
    logic        vector_taken;
    logic [2:0]  vector_num;
    logic        wake_up;
    logic        rd_d = 1'b0;
    logic [7:0]  rq[$];
    logic [7:0]  vq[$];
    int          fail_count = 0;
    int          checks_done = 0;
    int          seed = 32'h60A4;
    int          i;
    int          n;
    int          b;
    int          m;
    localparam int SUB_HALF = 8;
    logic [2:0]  v;
    logic [7:0]  d;
    itbu_if bus_if ();
    interrupt_and_time_base_unit i_interrupt_and_time_base_unit (.clk_sys(clk_sys), .rst(rst), .bus(bus_if),
        .sub_clock(sub_clock), .sim_byte_done(ev[0]), .sim_addr_match(ev[1]), .sim_bus_timeout(ev[2]),
        .uart_events(ev[8:3]), .eeprom_write_done(ev[9]), .low_voltage(ev[10]),
        .timer_module_match_a(ev[11]), .timer_module_match_p(ev[12]), .wake_up(wake_up));
    interrupt_core_end #(.STACK_DEPTH(8)) i_interrupt_core_end (.clk_sys(clk_sys), .rst(rst), .bus(bus_if),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .stack_used(stack_used), .ret_intr(ret_intr), .ret_plain(ret_plain), .vector_taken(vector_taken),
        .vector_num(vector_num));
    itbu_checker i_itbu_checker (.clk_sys(clk_sys), .rst(rst), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata), .irq_req(bus_if.irq_req), .irq_vec(bus_if.irq_vec),
        .irq_ack(bus_if.irq_ack), .stack_full(bus_if.stack_full),
        .return_from_interrupt_instr(bus_if.return_from_interrupt_instr),
        .plain_return_instr(bus_if.plain_return_instr));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // The sub clock toggles every SUB_HALF system clocks, driven right after a rising edge.
    always begin
        repeat (SUB_HALF) @(posedge clk_sys);
        sub_clock <= ~sub_clock;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] dv);
        sw_addr <= a;
        sw_wdata <= dv;
        sw_wr <= 1'b1;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        rq.push_back(exp);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic strobe(input int k);
        if (k < 13) ev[k] <= 1'b1;
        else if (k == 13) ret_plain <= 1'b1;
        else ret_intr <= 1'b1;
        @(posedge clk_sys);
        {ev, ret_plain, ret_intr} <= '0;
    endtask
    task automatic wait_for(input bit w, input int lim, input bit want, output int cnt);
        cnt = 0;
        #1;
        while (((w ? wake_up : vector_taken) !== 1'b1) && cnt < lim) begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
        check(w ? "wake_up" : "vector_taken", {7'h00, want}, {7'h00, cnt < lim});
        if (want && cnt >= lim) wrap_up();
        else @(posedge clk_sys);
    endtask
    // Monitor: compares read data and taken vectors against the oldest queued note.
    always @(posedge clk_sys) begin
        rd_d <= sw_rd;
        if (rd_d) check("sw_rdata", (rq.size() > 0) ? rq.pop_front() : 8'hXX, sw_rdata);
        if (vector_taken === 1'b1) check("vector_num", (vq.size() > 0) ? vq.pop_front() : 8'hXX, {5'h00, vector_num});
    end
    initial begin
        {ev, sw_addr, sw_wdata, sw_wr, sw_rd, stack_used, ret_intr, ret_plain} = '0;
        sub_clock = 1'b0;
        rst = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (i = 0; i < 9; i++) rd_reg(4'(i), 8'h00);
        for (i = 0; i < 4; i++) begin
            d = 8'($random(seed)) & 8'h7F;
            wr_reg(4'(i), d);
            rd_reg(4'(i), (i < 2) ? {6'h00, d[1:0]} : (d & 8'h07));
        end
        repeat (600) @(posedge clk_sys);
        rd_reg(OFF_FLAGS, 8'h00);
        // Pass 0: system clock, code 0; pass 1: divided clock, code 1; pass 2: sub clock, code 0.
        for (i = 0; i < 3; i++) begin
            b = i % 2;
            m = (32'h1 << (TB_BASE_EXP + b)) * ((i == 1) ? DIV4_COUNT : (i == 2) ? 2 * SUB_HALF : 1);
            wr_reg(OFF_PSC0 + 4'(b), 8'(i));
            wr_reg(OFF_TIME_BASE0_CONTROL + 4'(b), 8'h80 | 8'(b));
            wait_for(1'b1, 5000, 1'b1, n);
            check("tb_period", 8'h01, {7'h00, n > m - 17 && n < m + 8});
            rd_reg(OFF_FLAGS, 8'h01 << b);
            wr_reg(OFF_TIME_BASE0_CONTROL + 4'(b), 8'h00);
            wr_reg(OFF_FLAGS, 8'h00);
        end
        wr_reg(OFF_ENABLES, 8'hFC);
        wr_reg(OFF_GRP, 8'h70);
        for (i = 0; i < 13; i++) begin
            b = (i < 3) ? 2 : (i < 9) ? 3 : i - 5;
            v = (i < 3) ? VEC_SIM : (i < 9) ? VEC_UART : (i < 11) ? VEC_MF0 : 3'(i - 6);
            stack_used <= (i == 4) ? 5'd8 : 5'd0;
            strobe(i);
            wait_for(1'b1, 20, 1'b1, n);
            if (i[0]) begin
                strobe(13);
                repeat (5) @(posedge clk_sys);
            end
            vq.push_back({5'h00, v});
            if (i[0]) strobe(14);
            else wr_reg(OFF_GLOBAL, 8'h01);
            if (i == 4) begin
                repeat (10) @(posedge clk_sys);
                stack_used <= 5'd0;
            end
            wait_for(1'b0, 20, 1'b1, n);
            rd_reg(OFF_FLAGS, (i < 9) ? 8'h00 : 8'h01 << b);
            rd_reg(OFF_GRP, 8'h70);
            rd_reg(OFF_GLOBAL, 8'h00);
            wr_reg(OFF_FLAGS, 8'h00);
        end
        wr_reg(OFF_FLAGS, 8'h04);
        strobe(0);
        wait_for(1'b1, 10, 1'b0, n);
        wr_reg(OFF_FLAGS, 8'h00);
        vq.push_back({5'h00, VEC_SIM});
        vq.push_back({5'h00, VEC_UART});
        ev[0] <= 1'b1;
        ev[3] <= 1'b1;
        @(posedge clk_sys);
        ev <= '0;
        repeat (6) @(posedge clk_sys);
        wr_reg(OFF_GLOBAL, 8'h01);
        wait_for(1'b0, 20, 1'b1, n);
        wr_reg(OFF_GLOBAL, 8'h01);
        wait_for(1'b0, 20, 1'b1, n);
        repeat (4) @(posedge clk_sys);
        wrap_up();
    end
endmodule // tb_top
